// [bench/blc_nvm_model.sv]
/*
 * Behavioural non-volatile store on the loader's read port.
 * Assumes the bank requests by level and takes data on a one-cycle ack.
 */
module blc_nvm_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Store read port
	input wire logic nvm_rd_req,
	input wire logic [7:0] nvm_addr,
	output logic [7:0] nvm_rd_data,
	output logic nvm_rd_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:7];
	int wait_c;
	int n_acks;
	// Unassigned bits set on purpose so masking on load is visible
	initial begin
		mem = '{8'h00, 8'h00, 8'h5B, 8'hFB, 8'hA6, 8'h00, 8'hFD, 8'hFF};
	end
	// Alternates prompt and slow answers; the data line toggles when idle
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_rd_ack <= 1'h0;
			nvm_rd_data <= 8'hA5;
			wait_c = 0;
			n_acks = 0;
		end else if (nvm_rd_ack || !nvm_rd_req) begin
			nvm_rd_ack <= 1'h0;
			nvm_rd_data <= ~nvm_rd_data;
		end else if (wait_c >= 3 * (n_acks % 2)) begin
			nvm_rd_ack <= 1'h1;
			nvm_rd_data <= mem[nvm_addr[2:0]];
			wait_c = 0;
			n_acks = n_acks + 1;
		end else begin
			wait_c = wait_c + 1;
			nvm_rd_data <= ~nvm_rd_data;
		end
	end
endmodule // blc_nvm_model

// [bench/tb_blc_config_regs.sv]
/*
 * Self-checking bench of the configuration bank: reset defaults, load
 * from the store, host reads and writes, frequency and floor outputs.
 * Assumes blc_nvm_model stands on the store port.
 */
module tb_blc_config_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst_n, host_wr_en, host_rd_en, host_ready, host_rd_valid;
	logic nvm_rd_req, nvm_rd_ack, comp_internal, pfm_enable, led_short_enable;
	logic [7:0] host_addr, host_wr_data, host_rd_data, nvm_addr, nvm_rd_data;
	logic [1:0] uvlo_sel, switch_node_edge_rate, headroom_sel, led_ovp_sel;
	logic [4:0] output_overvoltage_limit;
	logic [3:0] switch_freq_code;
	logic [5:0] pfm_floor_code;
	logic [10:0] selected_switch_frequency;
	logic [9:0] pfm_floor_khz;
	int mismatches, n_tests;
	logic [7:0] seen_q [$];
	logic [7:0] addr_t [0:4] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07};
	logic [7:0] mask_t [0:4] = '{8'hFF, 8'h2F, 8'hFF, 8'h03, 8'h13};
	logic [7:0] dflt_t [0:4] = '{8'hE8, 8'h24, 8'hF3, 8'h02, 8'h00};
	logic [7:0] nvm_t [0:4] = '{8'h5B, 8'h2B, 8'hA6, 8'h01, 8'h13};
	logic [7:0] pat_t [0:2] = '{8'hFF, 8'h00, 8'h5A};
	logic [7:0] um_t [0:4] = '{8'h00, 8'h01, 8'h05, 8'h08, 8'hFF};
	int freq_t [0:15] = '{100, 150, 200, 250, 300, 400, 500, 600, 700, 800, 900, 1000,
		1225, 1335, 1450, 1600};

	blc_config_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .host_wr_en(host_wr_en),
		.host_rd_en(host_rd_en), .host_addr(host_addr), .host_wr_data(host_wr_data),
		.host_ready(host_ready), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
		.nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr), .nvm_rd_data(nvm_rd_data),
		.nvm_rd_ack(nvm_rd_ack), .uvlo_sel(uvlo_sel),
		.output_overvoltage_limit(output_overvoltage_limit), .comp_internal(comp_internal),
		.switch_freq_code(switch_freq_code), .pfm_enable(pfm_enable),
		.switch_node_edge_rate(switch_node_edge_rate), .pfm_floor_code(pfm_floor_code),
		.headroom_sel(headroom_sel), .led_ovp_sel(led_ovp_sel),
		.led_short_enable(led_short_enable),
		.selected_switch_frequency(selected_switch_frequency), .pfm_floor_khz(pfm_floor_khz));

	blc_nvm_model nvm_u (.core_clk(core_clk), .rst_n(rst_n), .nvm_rd_req(nvm_rd_req),
		.nvm_addr(nvm_addr), .nvm_rd_data(nvm_rd_data), .nvm_rd_ack(nvm_rd_ack));

	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end

	// Load order as the store sees it
	always @(posedge core_clk) begin
		if (nvm_rd_req && nvm_rd_ack) begin
			seen_q.push_back(nvm_addr);
		end
	end

	// Register image rebuilt from the field outputs
	function automatic logic [7:0] view(input int i);
		case (i)
			0: view = {comp_internal, output_overvoltage_limit, uvlo_sel};
			1: view = {2'h0, pfm_enable, 1'h0, switch_freq_code};
			2: view = {pfm_floor_code, switch_node_edge_rate};
			3: view = {6'h00, headroom_sel};
			default: view = {3'h0, led_short_enable, 2'h0, led_ovp_sel};
		endcase
	endfunction

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task do_reset;
		rst_n = 1'h0;
		repeat (10) @(negedge core_clk);
		for (int i = 0; i < 5; i++) chk({8'h00, view(i)}, {8'h00, dflt_t[i]});
		chk({15'h0000, host_ready}, 16'h0000);
		chk({5'h00, selected_switch_frequency}, 16'h012C);
		seen_q.delete();
		rst_n = 1'h1;
	endtask

	task wait_ready;
		int k;
		for (k = 0; k < 200 && host_ready !== 1'h1; k++) @(negedge core_clk);
		if (host_ready !== 1'h1) begin
			mismatches++;
			final_report;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		host_addr = a;
		host_wr_data = d;
		host_wr_en = 1'h1;
		@(negedge core_clk);
		host_wr_en = 1'h0;
		@(negedge core_clk);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		host_addr = a;
		host_rd_en = 1'h1;
		@(negedge core_clk);
		host_rd_en = 1'h0;
		chk({15'h0000, host_rd_valid}, 16'h0001);
		chk({8'h00, host_rd_data}, {8'h00, exp});
		@(negedge core_clk);
	endtask

	task check_store;
		chk(16'(seen_q.size()), 16'h0005);
		for (int i = 0; i < 5; i++) chk({8'h00, seen_q[i]}, {8'h00, addr_t[i]});
		for (int i = 0; i < 5; i++) rd(addr_t[i], nvm_t[i]);
		for (int i = 0; i < 5; i++) chk({8'h00, view(i)}, {8'h00, nvm_t[i]});
	endtask

	initial begin
		rst_n = 1'h0;
		host_wr_en = 1'h0;
		host_rd_en = 1'h0;
		host_addr = 8'h00;
		host_wr_data = 8'h00;
		mismatches = 0;
		n_tests = 0;
		do_reset;
		// A read while loading must be dropped without an answer
		host_addr = 8'h02;
		host_rd_en = 1'h1;
		repeat (3) begin
			@(negedge core_clk);
			chk({14'h0000, host_ready, host_rd_valid}, 16'h0000);
		end
		host_rd_en = 1'h0;
		wait_ready;
		check_store;
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 5; i++) wr(addr_t[i], pat_t[p]);
			for (int i = 0; i < 5; i++) rd(addr_t[i], pat_t[p] & mask_t[i]);
			for (int i = 0; i < 5; i++) chk({8'h00, view(i)}, {8'h00, pat_t[p] & mask_t[i]});
		end
		// Unmapped offsets take no write and read as zero
		for (int i = 0; i < 5; i++) wr(um_t[i], 8'hFF);
		for (int i = 0; i < 5; i++) rd(um_t[i], 8'h00);
		for (int i = 0; i < 5; i++) chk({8'h00, view(i)}, {8'h00, 8'h5A & mask_t[i]});
		// Write and read together: the read sees the old value
		host_addr = 8'h06;
		host_wr_data = 8'h03;
		host_wr_en = 1'h1;
		host_rd_en = 1'h1;
		@(negedge core_clk);
		host_wr_en = 1'h0;
		host_rd_en = 1'h0;
		chk({8'h00, host_rd_data}, 16'h0002);
		@(negedge core_clk);
		rd(8'h06, 8'h03);
		// Every frequency code, with a floor code that ends at 0x3C
		for (int c = 0; c < 16; c++) begin
			wr(8'h04, {c[3:0], 4'h1});
			wr(8'h03, {4'h2, c[3:0]});
			@(negedge core_clk);
			chk({5'h00, selected_switch_frequency}, 16'(freq_t[c]));
			chk({6'h00, pfm_floor_khz}, 16'(16000 / (16000 / freq_t[c] + 32 * c + 7)));
			chk({15'h0000, pfm_enable}, 16'h0001);
		end
		// Floor code 0 at 1600 kHz, then a read straight after a write
		wr(8'h04, 8'h00);
		chk({6'h00, pfm_floor_khz}, 16'(16000 / (16000 / 1600 + 7)));
		host_addr = 8'h03;
		host_wr_data = 8'hD7;
		host_wr_en = 1'h1;
		@(negedge core_clk);
		host_wr_en = 1'h0;
		host_rd_en = 1'h1;
		@(negedge core_clk);
		host_rd_en = 1'h0;
		chk({15'h0000, host_rd_valid}, 16'h0001);
		chk({8'h00, host_rd_data}, 16'h0007);
		@(negedge core_clk);
		wr(8'h03, 8'h0C);
		chk({15'h0000, pfm_enable}, 16'h0000);
		// Reset in mid-run brings back defaults, then the stored image
		do_reset;
		wait_ready;
		check_store;
		final_report;
	end
endmodule // tb_blc_config_regs

// [verilog/blc_config_regs.sv]
/*
 * Configuration register bank of a boost converter with LED driver:
 * protection, frequency and edge-rate fields driven to the analog core.
 * Assumes an I2C protocol engine presents decoded byte accesses on the
 * host port, synchronous to core_clk, and a non-volatile store port.
 */
`include "blc_params.svh"

// Behaviour
// - UVLO threshold field at 0x02[1:0], default 00 (2.3 V).
// - Output overvoltage code at 0x02[6:2], 10-40 V, default 0x1A.
// - Compensation select at 0x02[7], 1 internal, default internal.
// - Switching frequency code at 0x03[3:0], sixteen steps, default 0x04.
// - Pulse-frequency mode enable at 0x03[5], default on.
// - Switch node edge rate at 0x04[1:0], default 11 (200%).
// - PFM floor code at 0x04[7:2], default 0x3C, floor by formula.
// - Channel headroom at 0x06[1:0], default 10 (500 mV).
// - LED overvoltage level at 0x07[1:0], default 00 (2.1 V).
// - LED short protection enable at 0x07[4], default off.
// - Host reads and writes every field through the access port.
// - Registers load from the non-volatile store before host access.
module blc_config_regs
	import blc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Host access port from the I2C engine
	input wire logic host_wr_en,
	input wire logic host_rd_en,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wr_data,
	output logic host_ready,
	output logic [7:0] host_rd_data,
	output logic host_rd_valid,
	// Non-volatile store read port
	output logic nvm_rd_req,
	output logic [7:0] nvm_addr,
	input wire logic [7:0] nvm_rd_data,
	input wire logic nvm_rd_ack,
	// Fields to the analog core
	output logic [1:0] uvlo_sel,
	output logic [4:0] output_overvoltage_limit,
	output logic comp_internal,
	output logic [3:0] switch_freq_code,
	output logic pfm_enable,
	output logic [1:0] switch_node_edge_rate,
	output logic [5:0] pfm_floor_code,
	output logic [1:0] headroom_sel,
	output logic [1:0] led_ovp_sel,
	output logic led_short_enable,
	// Derived frequencies in kHz
	output logic [10:0] selected_switch_frequency,
	output logic [9:0] pfm_floor_khz
);

	logic ld_wr_en;
	logic [7:0] ld_addr;
	logic [7:0] ld_data;
	logic load_busy;

	logic [7:0] uvlo_ovp_comp_cfg_r, uvlo_ovp_comp_cfg_nxt;
	logic [7:0] switch_freq_cfg_r, switch_freq_cfg_nxt;
	logic [7:0] edge_rate_pfm_floor_cfg_r, edge_rate_pfm_floor_cfg_nxt;
	logic [7:0] headroom_cfg_r, headroom_cfg_nxt;
	logic [7:0] led_protect_cfg_r, led_protect_cfg_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [10:0] fsw_r, fsw_nxt;
	logic [9:0] floor_r, floor_nxt;

	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [13:0] floor_den;

	// Switching frequency in kHz for a code
	function automatic logic [10:0] freq_khz(input logic [3:0] code);
		logic [10:0] f;
		f = 11'h000;
		case (code)
			4'h0: f = 11'h064;
			4'h1: f = 11'h096;
			4'h2: f = 11'h0C8;
			4'h3: f = 11'h0FA;
			4'h4: f = 11'h12C;
			4'h5: f = 11'h190;
			4'h6: f = 11'h1F4;
			4'h7: f = 11'h258;
			4'h8: f = 11'h2BC;
			4'h9: f = 11'h320;
			4'hA: f = 11'h384;
			4'hB: f = 11'h3E8;
			4'hC: f = 11'h4C9;
			4'hD: f = 11'h537;
			4'hE: f = 11'h5AA;
			4'hF: f = 11'h640;
			default: f = 11'h000;
		endcase
		return f;
	endfunction

	// Stored byte at an offset, reserved bits already zero
	function automatic logic [7:0] reg_value(input logic [7:0] addr, input logic [7:0] r2,
		input logic [7:0] r3, input logic [7:0] r4, input logic [7:0] r6, input logic [7:0] r7);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			`BLC_ADDR_UVLO_OVP: v = r2;
			`BLC_ADDR_FREQ: v = r3;
			`BLC_ADDR_EDGE_FLOOR: v = r4;
			`BLC_ADDR_HEADROOM: v = r6;
			`BLC_ADDR_LED_PROT: v = r7;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	blc_nvm_loader u_loader (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.nvm_rd_req(nvm_rd_req),
		.nvm_addr(nvm_addr),
		.nvm_rd_data(nvm_rd_data),
		.nvm_rd_ack(nvm_rd_ack),
		.ld_wr_en(ld_wr_en),
		.ld_addr(ld_addr),
		.ld_data(ld_data),
		.load_busy(load_busy)
	);

	// Host is held off until the store has been copied in
	assign host_ready = !load_busy;
	assign wr_en = load_busy ? ld_wr_en : host_wr_en;
	assign wr_addr = load_busy ? ld_addr : host_addr;
	assign wr_data = (load_busy ? ld_data : host_wr_data) & blc_addr_mask(wr_addr);

	// Floor period in units of 1/16000 ms; worst case stays below 680
	assign floor_den = 14'(16'(`BLC_FLOOR_NUMERATOR) / 16'(freq_khz(switch_freq_code)))
		+ 14'({pfm_floor_code, 3'b000}) + 14'(`BLC_FLOOR_OFFSET);

	always_comb begin
		uvlo_ovp_comp_cfg_nxt = uvlo_ovp_comp_cfg_r;
		switch_freq_cfg_nxt = switch_freq_cfg_r;
		edge_rate_pfm_floor_cfg_nxt = edge_rate_pfm_floor_cfg_r;
		headroom_cfg_nxt = headroom_cfg_r;
		led_protect_cfg_nxt = led_protect_cfg_r;
		if (wr_en) begin
			unique case (wr_addr)
				`BLC_ADDR_UVLO_OVP: uvlo_ovp_comp_cfg_nxt = wr_data;
				`BLC_ADDR_FREQ: switch_freq_cfg_nxt = wr_data;
				`BLC_ADDR_EDGE_FLOOR: edge_rate_pfm_floor_cfg_nxt = wr_data;
				`BLC_ADDR_HEADROOM: headroom_cfg_nxt = wr_data;
				`BLC_ADDR_LED_PROT: led_protect_cfg_nxt = wr_data;
				default: begin
				end
			endcase
		end
		rd_valid_nxt = host_rd_en && !load_busy;
		rd_data_nxt = rd_data_r;
		if (host_rd_en && !load_busy) begin
			rd_data_nxt = reg_value(host_addr, uvlo_ovp_comp_cfg_r, switch_freq_cfg_r,
				edge_rate_pfm_floor_cfg_r, headroom_cfg_r, led_protect_cfg_r);
		end
		fsw_nxt = freq_khz(switch_freq_code);
		floor_nxt = 10'(`BLC_FLOOR_NUMERATOR / floor_den);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			uvlo_ovp_comp_cfg_r <= `BLC_RST_UVLO_OVP;
			switch_freq_cfg_r <= `BLC_RST_FREQ;
			edge_rate_pfm_floor_cfg_r <= `BLC_RST_EDGE_FLOOR;
			headroom_cfg_r <= `BLC_RST_HEADROOM;
			led_protect_cfg_r <= `BLC_RST_LED_PROT;
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
			fsw_r <= 11'h12C;
			floor_r <= 10'h000;
		end else begin
			uvlo_ovp_comp_cfg_r <= uvlo_ovp_comp_cfg_nxt;
			switch_freq_cfg_r <= switch_freq_cfg_nxt;
			edge_rate_pfm_floor_cfg_r <= edge_rate_pfm_floor_cfg_nxt;
			headroom_cfg_r <= headroom_cfg_nxt;
			led_protect_cfg_r <= led_protect_cfg_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			fsw_r <= fsw_nxt;
			floor_r <= floor_nxt;
		end
	end

	assign uvlo_sel = uvlo_ovp_comp_cfg_r[`BLC_UVLO_LSB +: 2];
	assign output_overvoltage_limit = uvlo_ovp_comp_cfg_r[`BLC_OVP_LSB +: 5];
	assign comp_internal = uvlo_ovp_comp_cfg_r[`BLC_COMP_BIT];
	assign switch_freq_code = switch_freq_cfg_r[`BLC_FREQ_LSB +: 4];
	// Floor only matters to the core while PFM is on
	assign pfm_enable = switch_freq_cfg_r[`BLC_PFM_BIT];
	assign switch_node_edge_rate = edge_rate_pfm_floor_cfg_r[`BLC_EDGE_LSB +: 2];
	assign pfm_floor_code = edge_rate_pfm_floor_cfg_r[`BLC_FLOOR_LSB +: 6];
	assign headroom_sel = headroom_cfg_r[`BLC_HEADROOM_LSB +: 2];
	assign led_ovp_sel = led_protect_cfg_r[`BLC_LED_OVP_LSB +: 2];
	assign led_short_enable = led_protect_cfg_r[`BLC_SHORT_BIT];
	assign host_rd_data = rd_data_r;
	assign host_rd_valid = rd_valid_r;
	assign selected_switch_frequency = fsw_r;
	assign pfm_floor_khz = floor_r;

	uvlo_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h02 |=> uvlo_sel == $past(host_wr_data[1:0]))
		else $error("UVLO field did not take host write");
	ovp_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h02
		|=> output_overvoltage_limit == $past(host_wr_data[6:2]))
		else $error("Overvoltage field did not take host write");
	comp_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h02 |=> comp_internal == $past(host_wr_data[7]))
		else $error("Compensation select did not take host write");
	freq_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h03 && host_wr_data[3:0] == 4'hC
		|=> ##1 selected_switch_frequency == 11'h4C9)
		else $error("Frequency code 0xC did not give 1225 kHz");
	pfm_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h03 |=> pfm_enable == $past(host_wr_data[5]))
		else $error("PFM enable did not take host write");
	edge_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h04
		|=> switch_node_edge_rate == $past(host_wr_data[1:0]))
		else $error("Edge rate did not take host write");
	floor_calc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h04 && host_wr_data == 8'h00
		&& switch_freq_code == 4'hF && !(host_wr_en && host_addr == 8'h03)
		|=> ##1 pfm_floor_khz == 10'h3AD)
		else $error("PFM floor formula wrong for code 0 at 1600 kHz");
	headroom_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h06 |=> headroom_sel == $past(host_wr_data[1:0]))
		else $error("Headroom did not take host write");
	led_ovp_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h07 |=> led_ovp_sel == $past(host_wr_data[1:0]))
		else $error("LED overvoltage level did not take host write");
	short_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h07 |=> led_short_enable == $past(host_wr_data[4]))
		else $error("Short protection enable did not take host write");
	read_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == 8'h03 ##1 host_rd_en && host_addr == 8'h03
		&& !host_wr_en |=> host_rd_valid && host_rd_data == ($past(host_wr_data, 2) & 8'h2F))
		else $error("Read back of frequency register wrong");
	busy_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!host_ready && !nvm_rd_ack |=> $stable(uvlo_ovp_comp_cfg_r) && $stable(led_protect_cfg_r)
		&& !host_rd_valid)
		else $error("Bank changed or answered while loading");

	// Host port framing and field writes
	rd_valid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_rd_en |=> host_rd_valid)
		else $error("Taken read gave no valid pulse");
	rd_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(host_ready && host_rd_en) |=> !host_rd_valid && $stable(host_rd_data))
		else $error("Read data moved or pulsed without a taken read");
	ready_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready |=> host_ready)
		else $error("Host port closed again after loading");
	freq_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == `BLC_ADDR_FREQ
		|=> switch_freq_code == $past(host_wr_data[3:0]))
		else $error("Frequency code did not take host write");
	floor_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && host_addr == `BLC_ADDR_EDGE_FLOOR
		|=> pfm_floor_code == $past(host_wr_data[7:2]))
		else $error("PFM floor code did not take host write");

	// Reserved bits and unmapped offsets
	unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_rd_en && blc_addr_mask(host_addr) == 8'h00
		|=> host_rd_data == 8'h00)
		else $error("Unmapped offset did not read as zero");
	unmapped_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_ready && host_wr_en && blc_addr_mask(host_addr) == 8'h00
		|=> $stable(uvlo_ovp_comp_cfg_r) && $stable(switch_freq_cfg_r)
		&& $stable(edge_rate_pfm_floor_cfg_r) && $stable(headroom_cfg_r)
		&& $stable(led_protect_cfg_r))
		else $error("Write to unmapped offset changed the bank");
	reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(switch_freq_cfg_r & ~`BLC_MASK_FREQ) == 8'h00
		&& (headroom_cfg_r & ~`BLC_MASK_HEADROOM) == 8'h00
		&& (led_protect_cfg_r & ~`BLC_MASK_LED_PROT) == 8'h00)
		else $error("Unassigned bit held a one");

	// Loader writes, masked on the way in
	load_uvlo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ld_wr_en && ld_addr == `BLC_ADDR_UVLO_OVP
		|=> uvlo_ovp_comp_cfg_r == $past(ld_data))
		else $error("Stored byte for the first register was not loaded");
	load_freq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ld_wr_en && ld_addr == `BLC_ADDR_FREQ
		|=> switch_freq_cfg_r == ($past(ld_data) & `BLC_MASK_FREQ))
		else $error("Stored frequency byte not loaded or not masked");
	load_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ld_wr_en && ld_addr == `BLC_ADDR_EDGE_FLOOR
		|=> edge_rate_pfm_floor_cfg_r == $past(ld_data))
		else $error("Stored edge rate byte was not loaded");
	load_prot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ld_wr_en && ld_addr == `BLC_ADDR_LED_PROT
		|=> led_protect_cfg_r == ($past(ld_data) & `BLC_MASK_LED_PROT))
		else $error("Stored protection byte not loaded or not masked");

endmodule // blc_config_regs

// [verilog/blc_nvm_loader.sv]
/*
 * Power-on loader: copies each configuration register from the
 * non-volatile store into the bank, one read per register.
 * Assumes the store answers each request with a one-cycle acknowledge.
 */
`include "blc_params.svh"

module blc_nvm_loader
	import blc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Non-volatile store read port
	output logic nvm_rd_req,
	output logic [7:0] nvm_addr,
	input wire logic [7:0] nvm_rd_data,
	input wire logic nvm_rd_ack,
	// Load path into the bank
	output logic ld_wr_en,
	output logic [7:0] ld_addr,
	output logic [7:0] ld_data,
	output logic load_busy
);

	blc_load_state_type state_r, state_nxt;
	logic [2:0] idx_r, idx_nxt;

	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		unique case (state_r)
			BLC_LD_REQ: begin
				state_nxt = BLC_LD_WAIT;
			end
			BLC_LD_WAIT: begin
				if (nvm_rd_ack) begin
					if (idx_r == `BLC_REG_COUNT - 3'h1) begin
						state_nxt = BLC_LD_DONE;
					end else begin
						idx_nxt = idx_r + 3'h1;
						state_nxt = BLC_LD_REQ;
					end
				end
			end
			BLC_LD_DONE: begin
				state_nxt = BLC_LD_DONE;
			end
			default: state_nxt = BLC_LD_DONE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= BLC_LD_REQ;
			idx_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Request stays up until acknowledged
	assign nvm_rd_req = (state_r == BLC_LD_WAIT);
	assign nvm_addr = blc_index_addr(idx_r);
	assign ld_wr_en = (state_r == BLC_LD_WAIT) && nvm_rd_ack;
	assign ld_addr = blc_index_addr(idx_r);
	assign ld_data = nvm_rd_data;
	assign load_busy = (state_r != BLC_LD_DONE);

endmodule // blc_nvm_loader

// [verilog/blc_params.svh]
/*
 * Offsets, field positions, write masks and power-on defaults of the
 * boost and LED driver configuration bank.
 * Assumes it is included by bare name wherever these macros are used.
 */
`ifndef BLC_PARAMS_SVH
`define BLC_PARAMS_SVH

// Register offsets
`define BLC_ADDR_UVLO_OVP 8'h02
`define BLC_ADDR_FREQ 8'h03
`define BLC_ADDR_EDGE_FLOOR 8'h04
`define BLC_ADDR_HEADROOM 8'h06
`define BLC_ADDR_LED_PROT 8'h07

// Implemented bits of each register; the rest read as zero
`define BLC_MASK_UVLO_OVP 8'hFF
`define BLC_MASK_FREQ 8'h2F
`define BLC_MASK_EDGE_FLOOR 8'hFF
`define BLC_MASK_HEADROOM 8'h03
`define BLC_MASK_LED_PROT 8'h13

// Power-on defaults: comp internal, OVP 0x1A, UVLO 00
`define BLC_RST_UVLO_OVP 8'hE8
// PFM on, frequency code 0x04
`define BLC_RST_FREQ 8'h24
// Floor code 0x3C, edge rate 11
`define BLC_RST_EDGE_FLOOR 8'hF3
`define BLC_RST_HEADROOM 8'h02
`define BLC_RST_LED_PROT 8'h00

// Field positions
`define BLC_UVLO_LSB 0
`define BLC_OVP_LSB 2
`define BLC_COMP_BIT 7
`define BLC_FREQ_LSB 0
`define BLC_PFM_BIT 5
`define BLC_EDGE_LSB 0
`define BLC_FLOOR_LSB 2
`define BLC_HEADROOM_LSB 0
`define BLC_LED_OVP_LSB 0
`define BLC_SHORT_BIT 4

// Pulse-frequency floor arithmetic and loader register count
`define BLC_FLOOR_NUMERATOR 14'h3E80
`define BLC_FLOOR_OFFSET 10'h007
`define BLC_REG_COUNT 3'h5

`endif

// [verilog/blc_pkg.sv]
/*
 * Types and shared decode functions of the configuration bank.
 * Assumes blc_params.svh is on the include path.
 */
`include "blc_params.svh"

package blc_pkg;

	typedef enum logic [1:0] {
		BLC_LD_REQ = 2'b00,
		BLC_LD_WAIT = 2'b01,
		BLC_LD_DONE = 2'b10
	} blc_load_state_type;

	// Walk order of the loader, giving both the store address and the bank address
	function automatic logic [7:0] blc_index_addr(input logic [2:0] idx);
		logic [7:0] a;
		a = 8'h00;
		case (idx)
			3'h0: a = `BLC_ADDR_UVLO_OVP;
			3'h1: a = `BLC_ADDR_FREQ;
			3'h2: a = `BLC_ADDR_EDGE_FLOOR;
			3'h3: a = `BLC_ADDR_HEADROOM;
			3'h4: a = `BLC_ADDR_LED_PROT;
			default: a = 8'h00;
		endcase
		return a;
	endfunction

	// Writable bits at an offset; zero for an unmapped offset
	function automatic logic [7:0] blc_addr_mask(input logic [7:0] addr);
		logic [7:0] m;
		m = 8'h00;
		case (addr)
			`BLC_ADDR_UVLO_OVP: m = `BLC_MASK_UVLO_OVP;
			`BLC_ADDR_FREQ: m = `BLC_MASK_FREQ;
			`BLC_ADDR_EDGE_FLOOR: m = `BLC_MASK_EDGE_FLOOR;
			`BLC_ADDR_HEADROOM: m = `BLC_MASK_HEADROOM;
			`BLC_ADDR_LED_PROT: m = `BLC_MASK_LED_PROT;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

endpackage : blc_pkg
